// ==== hdl/aocr_regs.sv ====
// Output configuration register bank of the converter, behind the
// serial port. Drives serializer, LVDS driver and clocking controls.
// Assumes serial pins are synchronous to clk_sys.
`timescale 1ns/10ps
module aocr_regs
  import aocr_pkg::*;
(
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic ce, // Clock enable, freezes state
  input wire logic spi_sclk, // Serial clock
  input wire logic spi_csb_n, // Serial chip select
  input wire logic spi_sdio_i, // Serial data in
  output logic spi_sdio_o, // Serial data out
  output logic spi_sdio_oe, // Serial data drive enable
  output logic [1:0] lane_ieee_q, // Reduced-range option per lane
  output logic [1:0] lane_invert_q, // Output invert per lane
  output logic [1:0] lane_twos_q, // Twos complement per lane
  output logic [3:0] lane_current_q, // Driver current code, 2/lane
  output logic [1:0] term_sel_q, // Termination resistor select
  output logic fco_drive_2x_q, // Frame clock double drive
  output logic dco_drive_2x_q, // Data clock double drive
  output logic [2:0] clk_div_q, // Clock divider ratio
  output logic [2:0] sample_phase_q, // Sampling delay, input cycles
  output logic [3:0] dco_phase_q, // Data clock phase code
  output logic cap_en_q, // Capability override active
  output logic [1:0] cap_res_q, // Active resolution select
  output logic [2:0] cap_rate_q, // Active max rate capability
  output logic sdio_pulldown_en_q, // Serial pin pull-down on
  output logic cm_gen_pd_q // Common-mode generator down
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] dev_index_q;
  logic [7:0] clk_div_reg_q;
  logic [7:0] out_mode_q [2];
  logic [1:0] term_q;
  logic [1:0] drive_q;
  logic [7:0] out_phase_q;
  logic [7:0] cap_pend_q;
  logic [7:0] cap_act_q;
  logic [7:0] pulldn_q;
  logic [7:0] cmgen_q;
  logic wr_stb;
  logic [12:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [1:0] data_sel;
  logic [1:0] clk_sel;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Readback shows the lowest selected channel's copy
  function automatic logic first_sel(input logic [1:0] m);
    first_sel = ~m[0] & m[1];
  endfunction : first_sel

  // Driver current follows option and termination, never software
  function automatic logic [1:0] cur_code(
    input logic ieee,
    input logic [1:0] term
  );
    if (ieee)
    begin
      cur_code = (term != 2'h0) ? AOCR_CUR_IEEE_TERM : AOCR_CUR_IEEE;
    end
    else
    begin
      cur_code = (term != 2'h0) ? AOCR_CUR_ANSI_TERM : AOCR_CUR_ANSI;
    end
  endfunction : cur_code

  // ----------------------------------------------------------------
  // Serial port engine
  // ----------------------------------------------------------------
  aocr_spi u_spi (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .sclk(spi_sclk),
    .csb_n(spi_csb_n),
    .sdio_i(spi_sdio_i),
    .sdio_o(spi_sdio_o),
    .sdio_oe(spi_sdio_oe),
    .wr_stb(wr_stb),
    .addr(addr),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  // Channel masks from the index register
  assign data_sel = dev_index_q[AOCR_IDX_DATA_LSB +: 2];
  assign clk_sel = {dev_index_q[AOCR_IDX_DCO_BIT],
                    dev_index_q[AOCR_IDX_FCO_BIT]};

  // ----------------------------------------------------------------
  // Global registers, updated on the write itself
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      dev_index_q <= AOCR_RST_DEV_INDEX;
      clk_div_reg_q <= AOCR_RST_CLK_DIV;
      term_q <= AOCR_RST_OUT_ADJ[AOCR_ADJ_TERM_LSB +: 2];
      out_phase_q <= AOCR_RST_OUT_PHASE;
      pulldn_q <= AOCR_RST_PULLDN;
      cmgen_q <= AOCR_RST_CMGEN;
    end
    else if (ce && wr_stb)
    begin
      if (addr == AOCR_ADDR_DEV_INDEX)
      begin
        dev_index_q <= wr_data;
      end
      else if (addr == AOCR_ADDR_CLK_DIV)
      begin
        clk_div_reg_q <= wr_data;
      end
      else if (addr == AOCR_ADDR_OUT_ADJ)
      begin
        term_q <= wr_data[AOCR_ADJ_TERM_LSB +: 2];
      end
      else if (addr == AOCR_ADDR_OUT_PHASE)
      begin
        // Codes above 1011 stored as written, effect undefined
        out_phase_q <= wr_data;
      end
      else if (addr == AOCR_ADDR_PULLDN)
      begin
        pulldn_q <= wr_data;
      end
      else if (addr == AOCR_ADDR_CMGEN)
      begin
        cmgen_q <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-channel registers, written to every selected channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      out_mode_q[0] <= AOCR_RST_OUT_MODE;
      out_mode_q[1] <= AOCR_RST_OUT_MODE;
      drive_q <= {2{AOCR_RST_OUT_ADJ[AOCR_ADJ_DRIVE_BIT]}};
    end
    else if (ce && wr_stb)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (addr == AOCR_ADDR_OUT_MODE && data_sel[i])
        begin
          out_mode_q[i] <= wr_data;
        end
        else if (addr == AOCR_ADDR_OUT_ADJ && clk_sel[i])
        begin
          // Only a selected clock output takes the drive bit
          drive_q[i] <= wr_data[AOCR_ADJ_DRIVE_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Capability override: pending copy and transfer
  // ----------------------------------------------------------------
  // Held pending so resolution and rate change together
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cap_pend_q <= AOCR_RST_CAP_DOWN;
      cap_act_q <= AOCR_RST_CAP_DOWN;
    end
    else if (ce && wr_stb)
    begin
      if (addr == AOCR_ADDR_CAP_DOWN)
      begin
        cap_pend_q <= wr_data;
      end
      else if (addr == AOCR_ADDR_XFER && wr_data[AOCR_XFER_BIT])
      begin
        cap_act_q <= cap_pend_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Transfer bit is self-clearing, so it always reads zero
  always_comb
  begin
    rd_data = 8'h00;
    if (addr == AOCR_ADDR_DEV_INDEX)
    begin
      rd_data = dev_index_q;
    end
    else if (addr == AOCR_ADDR_CLK_DIV)
    begin
      rd_data = clk_div_reg_q;
    end
    else if (addr == AOCR_ADDR_OUT_MODE)
    begin
      rd_data = out_mode_q[first_sel(data_sel)] & 8'h45;
    end
    else if (addr == AOCR_ADDR_OUT_ADJ)
    begin
      rd_data = {2'h0, term_q, 3'h0, drive_q[first_sel(clk_sel)]};
    end
    else if (addr == AOCR_ADDR_OUT_PHASE)
    begin
      rd_data = out_phase_q & 8'h7F;
    end
    else if (addr == AOCR_ADDR_CAP_DOWN)
    begin
      rd_data = cap_pend_q & 8'h77;
    end
    else if (addr == AOCR_ADDR_PULLDN)
    begin
      rd_data = pulldn_q & 8'h01;
    end
    else if (addr == AOCR_ADDR_CMGEN)
    begin
      rd_data = cmgen_q & 8'h08;
    end
  end

  // ----------------------------------------------------------------
  // Lane controls toward the serializer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      lane_ieee_q <= {2{AOCR_RST_OUT_MODE[AOCR_MODE_IEEE_BIT]}};
      lane_invert_q <= {2{AOCR_RST_OUT_MODE[AOCR_MODE_INV_BIT]}};
      lane_twos_q <= {2{AOCR_RST_OUT_MODE[AOCR_MODE_FMT_BIT]}};
      lane_current_q <= {AOCR_CUR_ANSI, AOCR_CUR_ANSI};
    end
    else if (ce)
    begin
      for (int i = 0; i < 2; i++)
      begin
        lane_ieee_q[i] <= out_mode_q[i][AOCR_MODE_IEEE_BIT];
        lane_invert_q[i] <= out_mode_q[i][AOCR_MODE_INV_BIT];
        lane_twos_q[i] <= out_mode_q[i][AOCR_MODE_FMT_BIT];
        lane_current_q[2*i +: 2] <=
          cur_code(out_mode_q[i][AOCR_MODE_IEEE_BIT], term_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // Driver termination and clock output drive
  // ----------------------------------------------------------------
  // Double drive cannot coexist with termination; termination wins
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      term_sel_q <= AOCR_RST_OUT_ADJ[AOCR_ADJ_TERM_LSB +: 2];
      fco_drive_2x_q <= 1'b0;
      dco_drive_2x_q <= 1'b0;
    end
    else if (ce)
    begin
      term_sel_q <= term_q;
      fco_drive_2x_q <= drive_q[AOCR_CLK_FCO] & (term_q == 2'h0);
      dco_drive_2x_q <= drive_q[AOCR_CLK_DCO] & (term_q == 2'h0);
    end
  end

  // ----------------------------------------------------------------
  // Clocking: divider, sampling phase, data clock phase
  // ----------------------------------------------------------------
  // Phase above a nonzero divider ratio is software's fault; passed as is
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      clk_div_q <= AOCR_RST_CLK_DIV[AOCR_DIV_LSB +: 3];
      sample_phase_q <= AOCR_RST_OUT_PHASE[AOCR_PH_IN_LSB +: 3];
      dco_phase_q <= AOCR_RST_OUT_PHASE[AOCR_PH_OUT_LSB +: 4];
    end
    else if (ce)
    begin
      clk_div_q <= clk_div_reg_q[AOCR_DIV_LSB +: 3];
      if (clk_div_reg_q[AOCR_DIV_LSB +: 3] != 3'h0)
      begin
        sample_phase_q <= out_phase_q[AOCR_PH_IN_LSB +: 3];
      end
      else
      begin
        sample_phase_q <= 3'h0;
      end
      dco_phase_q <= out_phase_q[AOCR_PH_OUT_LSB +: 4];
    end
  end

  // ----------------------------------------------------------------
  // Capability outputs and auxiliary controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cap_en_q <= AOCR_RST_CAP_DOWN[AOCR_CAP_EN_BIT];
      cap_res_q <= AOCR_RST_CAP_DOWN[AOCR_CAP_RES_LSB +: 2];
      cap_rate_q <= AOCR_RST_CAP_DOWN[AOCR_CAP_RATE_LSB +: 3];
      sdio_pulldown_en_q <= ~AOCR_RST_PULLDN[AOCR_PULLDN_BIT];
      cm_gen_pd_q <= AOCR_RST_CMGEN[AOCR_CMGEN_PD_BIT];
    end
    else if (ce)
    begin
      // Rate field is a capability limit, not the sample clock
      cap_en_q <= cap_act_q[AOCR_CAP_EN_BIT];
      cap_res_q <= cap_act_q[AOCR_CAP_RES_LSB +: 2];
      cap_rate_q <= cap_act_q[AOCR_CAP_RATE_LSB +: 3];
      sdio_pulldown_en_q <= ~pulldn_q[AOCR_PULLDN_BIT];
      cm_gen_pd_q <= cmgen_q[AOCR_CMGEN_PD_BIT];
    end
  end

endmodule : aocr_regs

// ==== include/aocr_pkg.sv ====
// Shared constants for the output configuration register bank.
// Assumes a converter serializer and clock tree consuming the outputs.
package aocr_pkg;

  // ----------------------------------------------------------------
  // Register addresses (13-bit serial port address space)
  // ----------------------------------------------------------------
  localparam logic [12:0] AOCR_ADDR_DEV_INDEX = 13'h0005;
  localparam logic [12:0] AOCR_ADDR_CLK_DIV = 13'h000B;
  localparam logic [12:0] AOCR_ADDR_OUT_MODE = 13'h0014;
  localparam logic [12:0] AOCR_ADDR_OUT_ADJ = 13'h0015;
  localparam logic [12:0] AOCR_ADDR_OUT_PHASE = 13'h0016;
  localparam logic [12:0] AOCR_ADDR_XFER = 13'h00FF;
  localparam logic [12:0] AOCR_ADDR_CAP_DOWN = 13'h0100;
  localparam logic [12:0] AOCR_ADDR_PULLDN = 13'h0101;
  localparam logic [12:0] AOCR_ADDR_CMGEN = 13'h0102;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AOCR_IDX_DATA_LSB = 0;
  localparam int AOCR_IDX_FCO_BIT = 4;
  localparam int AOCR_IDX_DCO_BIT = 5;
  localparam int AOCR_DIV_LSB = 0;
  localparam int AOCR_MODE_IEEE_BIT = 6;
  localparam int AOCR_MODE_INV_BIT = 2;
  localparam int AOCR_MODE_FMT_BIT = 0;
  localparam int AOCR_ADJ_TERM_LSB = 4;
  localparam int AOCR_ADJ_DRIVE_BIT = 0;
  localparam int AOCR_PH_IN_LSB = 4;
  localparam int AOCR_PH_OUT_LSB = 0;
  localparam int AOCR_XFER_BIT = 0;
  localparam int AOCR_CAP_EN_BIT = 6;
  localparam int AOCR_CAP_RES_LSB = 4;
  localparam int AOCR_CAP_RATE_LSB = 0;
  localparam int AOCR_PULLDN_BIT = 0;
  localparam int AOCR_CMGEN_PD_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] AOCR_RST_DEV_INDEX = 8'h33;
  localparam logic [7:0] AOCR_RST_CLK_DIV = 8'h00;
  localparam logic [7:0] AOCR_RST_OUT_MODE = 8'h01;
  localparam logic [7:0] AOCR_RST_OUT_ADJ = 8'h00;
  localparam logic [7:0] AOCR_RST_OUT_PHASE = 8'h03;
  localparam logic [7:0] AOCR_RST_CAP_DOWN = 8'h00;
  localparam logic [7:0] AOCR_RST_PULLDN = 8'h00;
  localparam logic [7:0] AOCR_RST_CMGEN = 8'h00;

  // ----------------------------------------------------------------
  // Serial framing, channels and driver current codes
  // ----------------------------------------------------------------
  localparam logic [4:0] AOCR_INSTR_BITS = 5'h10;
  localparam logic [2:0] AOCR_LAST_BIT = 3'h7;
  localparam int AOCR_CLK_FCO = 0;
  localparam int AOCR_CLK_DCO = 1;
  localparam logic [1:0] AOCR_CUR_ANSI = 2'h2;
  localparam logic [1:0] AOCR_CUR_ANSI_TERM = 2'h3;
  localparam logic [1:0] AOCR_CUR_IEEE = 2'h0;
  localparam logic [1:0] AOCR_CUR_IEEE_TERM = 2'h1;

  typedef enum logic [0:0] {AOCR_ST_INSTR, AOCR_ST_DATA} aocr_spi_state_e;

endpackage : aocr_pkg

// ==== hdl/aocr_spi.sv ====
// Serial port slave: 16-bit instruction then data bytes, MSB first.
// Assumes sclk, csb and sdio are already synchronous to clk_sys.
`timescale 1ns/10ps
module aocr_spi
  import aocr_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic sclk, // Serial clock level
  input wire logic csb_n, // Chip select, active low
  input wire logic sdio_i, // Serial data in
  output logic sdio_o, // Serial data out
  output logic sdio_oe, // Serial data drive enable
  output logic wr_stb, // One-cycle write pulse
  output logic [12:0] addr, // Current byte address
  output logic [7:0] wr_data, // Written byte
  input wire logic [7:0] rd_data // Read byte for addr
);

  aocr_spi_state_e state_q;
  logic sclk_q;
  logic rise;
  logic fall;
  logic [15:0] sh_q;
  logic [4:0] icnt_q;
  logic [2:0] bcnt_q;
  logic rd_q;
  logic byte_done_q;
  logic [7:0] tx_q;

  assign rise = sclk & ~sclk_q;
  assign fall = ~sclk & sclk_q;

  // ----------------------------------------------------------------
  // Edge detection and framing
  // ----------------------------------------------------------------
  // Streaming runs until chip select rises; the length bits are unused
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_q <= 1'b0;
      state_q <= AOCR_ST_INSTR;
      sh_q <= 16'h0000;
      icnt_q <= 5'h00;
      bcnt_q <= 3'h0;
      rd_q <= 1'b0;
      byte_done_q <= 1'b0;
      addr <= 13'h0000;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
    end
    else if (ce)
    begin
      sclk_q <= sclk;
      wr_stb <= 1'b0;
      if (csb_n)
      begin
        state_q <= AOCR_ST_INSTR;
        icnt_q <= 5'h00;
        bcnt_q <= 3'h0;
        rd_q <= 1'b0;
      end
      else if (rise)
      begin
        sh_q <= {sh_q[14:0], sdio_i};
        case (state_q)
          AOCR_ST_INSTR:
          begin
            icnt_q <= icnt_q + 5'h01;
            if (icnt_q == AOCR_INSTR_BITS - 5'h01)
            begin
              rd_q <= sh_q[14];
              addr <= {sh_q[11:0], sdio_i};
              state_q <= AOCR_ST_DATA;
            end
          end
          default:
          begin
            bcnt_q <= bcnt_q + 3'h1;
            if (bcnt_q == AOCR_LAST_BIT)
            begin
              wr_stb <= ~rd_q;
              wr_data <= {sh_q[6:0], sdio_i};
            end
          end
        endcase
      end
      // Step the address a cycle after the byte, so the write strobe
      // still sees the old address (descending order)
      byte_done_q <= !csb_n && wr_stb_next_addr(rise, state_q, bcnt_q);
      if (byte_done_q)
      begin
        addr <= addr - 13'h0001;
      end
    end
  end

  // Address advances only after a full data byte
  function automatic logic wr_stb_next_addr(
    input logic r,
    input aocr_spi_state_e s,
    input logic [2:0] b
  );
    wr_stb_next_addr = r && s == AOCR_ST_DATA && b == AOCR_LAST_BIT;
  endfunction : wr_stb_next_addr

  // ----------------------------------------------------------------
  // Read data shifter, launched on falling sclk
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_q <= 8'h00;
      sdio_o <= 1'b0;
      sdio_oe <= 1'b0;
    end
    else if (ce)
    begin
      if (csb_n)
      begin
        sdio_oe <= 1'b0;
      end
      else if (fall && state_q == AOCR_ST_DATA && rd_q)
      begin
        sdio_oe <= 1'b1;
        if (bcnt_q == 3'h0)
        begin
          sdio_o <= rd_data[7];
          tx_q <= {rd_data[6:0], 1'b0};
        end
        else
        begin
          sdio_o <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

endmodule : aocr_spi

// ==== verif/aocr_regs_assertions.sv ====
// Concurrent checks on the output configuration register bank.
// Assumes binding to aocr_regs; sees only its ports.
`timescale 1ns/10ps
module aocr_regs_assertions (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic spi_csb_n, // Serial chip select
  input wire logic [1:0] lane_ieee_q, // Reduced-range option
  input wire logic [1:0] lane_invert_q, // Stream invert
  input wire logic [1:0] lane_twos_q, // Number format
  input wire logic [3:0] lane_current_q, // Current codes
  input wire logic [1:0] term_sel_q, // Termination select
  input wire logic fco_drive_2x_q, // Frame clock drive
  input wire logic dco_drive_2x_q, // Data clock drive
  input wire logic [2:0] clk_div_q, // Divider ratio
  input wire logic [2:0] sample_phase_q, // Sampling delay
  input wire logic [3:0] dco_phase_q, // Data clock phase
  input wire logic cap_en_q, // Override active
  input wire logic [1:0] cap_res_q, // Resolution select
  input wire logic [2:0] cap_rate_q, // Rate capability
  input wire logic sdio_pulldown_en_q, // Pin pull-down
  input wire logic cm_gen_pd_q // Common-mode power-down
);
  // ------------------------------------------------------------------
  // Checks, one clock domain
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // Current follows option and termination, never software
  cur0_map_a: assert property (lane_current_q[1:0] ==
    {~lane_ieee_q[0], |term_sel_q}) else $error("lane0 current code");
  cur1_map_a: assert property (lane_current_q[3:2] ==
    {~lane_ieee_q[1], |term_sel_q}) else $error("lane1 current code");
  // Termination wins over double clock drive
  fco_term_a: assert property (fco_drive_2x_q |-> term_sel_q == 2'h0)
    else $error("frame clock doubled with termination");
  dco_term_a: assert property (dco_drive_2x_q |-> term_sel_q == 2'h0)
    else $error("data clock doubled with termination");
  // Sampling delay only when the divider is in use
  phase_gate_a: assert property (clk_div_q == 3'h0 |->
    sample_phase_q == 3'h0) else $error("phase without divider");
  // Lane option, invert and format, termination, data clock phase, override and common-mode outputs hold while the serial port sits idle
  quiet_hold_a: assert property (spi_csb_n [*8] |-> $stable({lane_ieee_q,
    lane_invert_q, lane_twos_q, term_sel_q, dco_phase_q, cap_en_q,
    cap_res_q, cap_rate_q, cm_gen_pd_q})) else $error("change while idle");
  // Rate capability leaves the real clocking alone
  rate_only_a: assert property ($changed(cap_rate_q) |->
    $stable(clk_div_q) && $stable(sample_phase_q)) else $error("rate moved clock");
  // Override lands alone, on the transfer write
  cap_alone_a: assert property ($changed({cap_en_q, cap_res_q, cap_rate_q})
    |-> $stable({lane_ieee_q, term_sel_q, dco_phase_q, sdio_pulldown_en_q}))
    else $error("override landed with other write");
endmodule : aocr_regs_assertions

// ==== verif/aocr_spi_host.sv ====
// Serial port host model: 16-bit instruction, one data byte.
// Assumes a resolved data line fed back on sd_i.
`timescale 1ns/10ps
module aocr_spi_host (
  input wire logic clk_sys, // System clock
  output logic sclk, // Serial clock, idle low
  output logic csb_n, // Chip select, active low
  output logic sd_o, // Host data
  output logic sd_oe, // Host drives data line
  input wire logic sd_i // Resolved data line
);
  initial
  begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sd_o = 1'b0;
    sd_oe = 1'b0;
  end

  // One bit: 4 clocks low, sample, 3 clocks high; slow for the sampler
  task automatic bit_cyc(input logic b, output logic r);
    sd_o <= b;
    sclk <= 1'b0;
    repeat (4) @(posedge clk_sys);
    r = sd_i;
    sclk <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : bit_cyc

  // Whole frame; data line released for reads so the device drives it
  task automatic xfer(input logic rd, input logic [12:0] a,
    input logic [7:0] wd, output logic [7:0] q);
    logic [15:0] ins;
    logic r;
    ins = {rd, 2'b00, a};
    @(posedge clk_sys);
    csb_n <= 1'b0;
    sd_oe <= 1'b1;
    for (int i = 15; i >= 0; i--) bit_cyc(ins[i], r);
    sd_oe <= !rd;
    for (int i = 7; i >= 0; i--) bit_cyc(wd[i], q[i]);
    sclk <= 1'b0;
    repeat (2) @(posedge clk_sys);
    csb_n <= 1'b1;
    sd_oe <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : xfer
endmodule : aocr_spi_host

// ==== verif/aocr_regs_tb.sv ====
// Self-checking bench for the register bank through its serial port.
// Assumes the host model drives the pins; checker bound below.
`timescale 1ns/10ps
module aocr_regs_tb;
  import aocr_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic sclk, csb_n, h_o, h_oe, d_o, d_oe, frame_clock_output, data_clock_output, cap_en, pd_en, cm;
  logic [1:0] ieee, inv, twos, term, res;
  logic [3:0] cur, ph_o;
  logic [2:0] div, ph_i, rate;
  int error_cnt = 0;
  int n_checks = 0;
  // Released line: pull-down if on, else a value that is surely stale
  wire sdio = d_oe ? d_o : h_oe ? h_o : pd_en ? 1'b0 : ~h_o;

  always #20 clk_sys = ~clk_sys;

  aocr_spi_host host (.clk_sys(clk_sys), .sclk(sclk), .csb_n(csb_n),
    .sd_o(h_o), .sd_oe(h_oe), .sd_i(sdio));
  aocr_regs uut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .spi_sclk(sclk),
    .spi_csb_n(csb_n), .spi_sdio_i(sdio), .spi_sdio_o(d_o),
    .spi_sdio_oe(d_oe), .lane_ieee_q(ieee), .lane_invert_q(inv),
    .lane_twos_q(twos), .lane_current_q(cur), .term_sel_q(term),
    .fco_drive_2x_q(frame_clock_output), .dco_drive_2x_q(data_clock_output), .clk_div_q(div),
    .sample_phase_q(ph_i), .dco_phase_q(ph_o), .cap_en_q(cap_en),
    .cap_res_q(res), .cap_rate_q(rate), .sdio_pulldown_en_q(pd_en),
    .cm_gen_pd_q(cm));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [12:0] a, output logic [7:0] q);
    host.xfer(1'b1, a, 8'h00, q);
  endtask : rd

  task automatic print_verdict;
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] q;
    chk(twos, 2'h3);
    chk(ph_o, 4'h3);
    chk(ph_i, 3'h0);
    chk(ieee, 2'h0);
    chk(cur, 4'hA);
    chk(pd_en, 1'b1);
    rd(AOCR_ADDR_OUT_MODE, q);
    chk(q, 8'h01);
    rd(AOCR_ADDR_OUT_PHASE, q);
    chk(q, 8'h03);
    rd(AOCR_ADDR_DEV_INDEX, q);
    chk(q, 8'h33);
    rd(13'h0050, q);
    chk(q, 8'h00);
  endtask : t_reset

  task automatic t_mode;
    logic [7:0] q;
    wr(AOCR_ADDR_OUT_MODE, 8'h44);
    chk(ieee, 2'h3);
    chk(inv, 2'h3);
    chk(twos, 2'h0);
    chk(cur, 4'h0);
    rd(AOCR_ADDR_OUT_MODE, q);
    chk(q, 8'h44);
  endtask : t_mode

  // Drive doubling, then termination overriding it
  task automatic t_drive;
    wr(AOCR_ADDR_OUT_ADJ, 8'h01);
    chk({frame_clock_output, data_clock_output}, 2'h3);
    wr(AOCR_ADDR_OUT_ADJ, 8'h21);
    chk(term, 2'h2);
    chk({frame_clock_output, data_clock_output}, 2'h0);
    chk(cur, 4'h5);
  endtask : t_drive

  // Channel select is written before the per-channel bit
  task automatic t_index;
    wr(AOCR_ADDR_DEV_INDEX, 8'h10);
    wr(AOCR_ADDR_OUT_ADJ, 8'h00);
    chk(term, 2'h0);
    chk({frame_clock_output, data_clock_output}, 2'h1);
    wr(AOCR_ADDR_DEV_INDEX, 8'h01);
    wr(AOCR_ADDR_OUT_MODE, 8'h00);
    chk(ieee, 2'h2);
    chk(cur, 4'h2);
    wr(AOCR_ADDR_DEV_INDEX, 8'h33);
  endtask : t_index

  // Phase first with divider off, then swept with divider raised; top code 1011 only
  task automatic t_phase;
    wr(AOCR_ADDR_OUT_PHASE, 8'h5B);
    chk(ph_o, 4'hB);
    chk(ph_i, 3'h0);
    wr(AOCR_ADDR_CLK_DIV, 8'h07);
    for (int p = 0; p < 8; p++)
    begin
      wr(AOCR_ADDR_OUT_PHASE, {1'b0, p[2:0], 4'h0});
      chk(ph_i, p[2:0]);
    end
    wr(AOCR_ADDR_CLK_DIV, 8'h00);
    chk(ph_i, 3'h0);
  endtask : t_phase

  task automatic t_override;
    wr(AOCR_ADDR_CAP_DOWN, 8'h56);
    chk({cap_en, res, rate}, 6'h00);
    wr(AOCR_ADDR_XFER, 8'h00);
    chk({cap_en, res, rate}, 6'h00);
    wr(AOCR_ADDR_XFER, 8'h01);
    chk({cap_en, res, rate}, 6'h2E);
    chk(div, 3'h0);
  endtask : t_override

  task automatic t_user;
    logic [7:0] q;
    wr(AOCR_ADDR_PULLDN, 8'h01);
    chk(pd_en, 1'b0);
    wr(AOCR_ADDR_PULLDN, 8'h00);
    chk(pd_en, 1'b1);
    wr(AOCR_ADDR_CMGEN, 8'h08);
    chk(cm, 1'b1);
    rd(AOCR_ADDR_CMGEN, q);
    chk(q, 8'h08);
  endtask : t_user

  // Clock enable low: a whole frame is ignored
  task automatic t_freeze;
    ce <= 1'b0;
    wr(AOCR_ADDR_PULLDN, 8'h01);
    ce <= 1'b1;
    chk(pd_en, 1'b1);
  endtask : t_freeze

  // Main sequence; watchdog cuts a hang short
  initial
  begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_mode();
    t_drive();
    t_index();
    t_phase();
    t_override();
    t_user();
    t_freeze();
    print_verdict();
  end

  initial
  begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    print_verdict();
  end
endmodule : aocr_regs_tb

bind aocr_regs aocr_regs_assertions chk_i (.clk_sys(clk_sys), .nrst(nrst),
  .spi_csb_n(spi_csb_n), .lane_ieee_q(lane_ieee_q),
  .lane_invert_q(lane_invert_q), .lane_twos_q(lane_twos_q),
  .lane_current_q(lane_current_q), .term_sel_q(term_sel_q),
  .fco_drive_2x_q(fco_drive_2x_q), .dco_drive_2x_q(dco_drive_2x_q),
  .clk_div_q(clk_div_q), .sample_phase_q(sample_phase_q),
  .dco_phase_q(dco_phase_q), .cap_en_q(cap_en_q), .cap_res_q(cap_res_q),
  .cap_rate_q(cap_rate_q), .sdio_pulldown_en_q(sdio_pulldown_en_q),
  .cm_gen_pd_q(cm_gen_pd_q));
